// File: port_controller_if_pkg.sv
// Overview of operation
// - VCONN fault flag set within 20 us
// - VCONN switch opens within 50 ns
// - Interrupt asserted within 4 ms of power-up
// - Sample CC and VBUS every 2 ms at reset (within 2.2); select also gives 1, 4 or 8 ms
// - Register set reachable by port manager host
// - Append 32-bit CRC, send frame on CC
// - Valid frame gets GoodCRC reply and interrupt
// - PHY enabled when attached and detect non-zero
// - PHY always disabled while unattached
// - Power role picks source or sink threshold
// - Threshold force uses programmed threshold value
// - Rp advertisement: default, 1.5 A, 3 A
// - Line non-idle after three transitions
package port_controller_if_pkg;

    // --------------------------------------------------------------
    // Register map (byte addresses)
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_ALERT = 8'h00;
    localparam logic [7:0] ADDR_ALERT_CLR = 8'h04;
    localparam logic [7:0] ADDR_ALERT_EN = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_TX_DATA = 8'h14;
    localparam logic [7:0] ADDR_RX_HEAD = 8'h18;
    localparam logic [7:0] ADDR_TX_CMD = 8'h1C;

    // --------------------------------------------------------------
    // Alert bits and reset values
    // --------------------------------------------------------------
    localparam int ALERT_W = 6;
    localparam int B_INIT = 0;
    localparam int B_VCONN = 1;
    localparam int B_RXMSG = 2;
    localparam int B_TXDONE = 3;
    localparam int B_RXBAD = 4;
    localparam int B_CCSAMP = 5;
    localparam logic [5:0] ALERT_EN_RESET = 6'h1F;

    // --------------------------------------------------------------
    // Control fields
    // --------------------------------------------------------------
    localparam int F_RXDET = 0;
    localparam int F_ROLE = 2;
    localparam int F_FORCE = 3;
    localparam int F_THRESH = 4;
    localparam int F_SAMP = 6;
    localparam int F_RP = 8;
    localparam int F_ATTACH = 10;
    localparam int F_VCONN = 13;
    localparam int CTRL_W = 14;
    localparam logic [13:0] CTRL_RESET = 14'h0040;
    localparam int F_TXLEN = 0;
    localparam int F_TXGO = 8;

    typedef enum logic [2:0] {
        ST_UNATTACHED, ST_ATTACHED_SNK, ST_ATTACHED_SRC, ST_DEBUG_ACC, ST_POWERED_ACC
    } attach_t;
    typedef enum logic [1:0] {TX_IDLE, TX_BODY, TX_CRC} tx_state_t;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int VCONN_FLAG_MAX_US = 20;
    localparam int VCONN_FLAG_CYC = VCONN_FLAG_MAX_US * CLK_MHZ;
    localparam int VCONN_OPEN_MAX_NS = 50;
    localparam int VCONN_OPEN_CYC = VCONN_OPEN_MAX_NS * CLK_MHZ / 1000;
    localparam int INIT_MAX_MS = 4;
    localparam int INIT_CYC = INIT_MAX_MS * CLK_MHZ * 1000;
    localparam int CC_PERIOD_US = 2000;
    localparam int CC_CYC = CC_PERIOD_US * CLK_MHZ;
    localparam int VBUS_MAX_US = 2200;
    localparam int BIT_RATE_KBPS = 300;
    localparam int HALF_BIT_CYC = CLK_MHZ * 1000 / BIT_RATE_KBPS / 2;
    localparam int RX_IDLE_CYC = 4 * HALF_BIT_CYC;
    localparam int N_TRANS = 3;

    // --------------------------------------------------------------
    // Frame check
    // --------------------------------------------------------------
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
    localparam logic [31:0] GOODCRC_WORD = 32'h00000001;
    localparam int MIN_RX_BITS = 64;

endpackage

// File: port_controller_if_core.sv
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
module port_controller_if_core import port_controller_if_pkg::*; #(
    parameter int INIT_CYCLES = INIT_CYC,
    parameter int CC_CYCLES = CC_CYC,
    parameter int TX_WORDS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic int_n,
    input wire logic vconn_fault,
    output logic vconn_sw,
    output logic phy_en,
    output logic [1:0] rx_thresh,
    output logic [1:0] rp_sel,
    output logic cc_sample_stb,
    output logic vbus_sample_stb,
    output logic tx_clk,
    output logic tx_data,
    output logic tx_oe,
    input wire logic rx_clk,
    input wire logic rx_data,
    input wire logic rx_frame
);

    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
        crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 32'h00000000);
    endfunction

    // ------------------------------------------------------------
    // Registers and bus decode
    // ------------------------------------------------------------
    logic [ALERT_W-1:0] alert;
    logic [ALERT_W-1:0] alert_en;
    logic [CTRL_W-1:0] ctrl;
    logic [3:0] tx_len;
    logic [31:0] tx_mem [TX_WORDS];
    logic [3:0] wr_ptr;
    logic [31:0] rx_head;
    logic [ALERT_W-1:0] set_ev;
    logic line_busy;
    tx_state_t tx_state;

    wire setup_done = psel & penable & ~pready;
    wire wr_go = psel & penable & pready & pwrite;
    wire wr_alert_clr = wr_go & (paddr == ADDR_ALERT_CLR);
    wire wr_alert_en = wr_go & (paddr == ADDR_ALERT_EN);
    wire wr_ctrl = wr_go & (paddr == ADDR_CTRL);
    wire wr_tx_data = wr_go & (paddr == ADDR_TX_DATA);
    wire wr_tx_cmd = wr_go & (paddr == ADDR_TX_CMD);
    wire addr_hit = (paddr[7:5] == 3'h0) & (paddr[1:0] == 2'h0);
    wire [ALERT_W-1:0] clr_mask = wr_alert_clr ? pwdata[ALERT_W-1:0] : '0;
    wire [31:0] status_word = {28'h0000000, (tx_state != TX_IDLE), line_busy, phy_en, vconn_sw};
    wire [31:0] rd_mux =
        (paddr == ADDR_ALERT) ? {26'h0000000, alert} :
        (paddr == ADDR_ALERT_EN) ? {26'h0000000, alert_en} :
        (paddr == ADDR_CTRL) ? {18'h00000, ctrl} :
        (paddr == ADDR_STATUS) ? status_word :
        (paddr == ADDR_RX_HEAD) ? rx_head :
        (paddr == ADDR_TX_CMD) ? {28'h0000000, tx_len} : 32'h00000000;

    // One wait state; register set reachable by the host
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_done;
            pslverr <= setup_done & ~addr_hit;
            prdata <= (setup_done & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    wire [2:0] attach_f = ctrl[F_ATTACH+:3];
    wire attached = (attach_f != 3'(ST_UNATTACHED)) & (attach_f <= 3'(ST_POWERED_ACC));
    wire [1:0] rp_f = ctrl[F_RP+:2];
    logic fault_s1;
    logic fault_s2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            alert_en <= ALERT_EN_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= pwdata[CTRL_W-1:0];
            end
            if (fault_s2) begin
                ctrl[F_VCONN] <= 1'b0; // Fault keeps switch open until rewritten
            end
            if (wr_alert_en) begin
                alert_en <= pwdata[ALERT_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_en <= 1'b0;
            rx_thresh <= 2'h0;
            rp_sel <= 2'h0;
        end else begin
            phy_en <= attached & (ctrl[F_RXDET+:2] != 2'h0);
            rx_thresh <= ctrl[F_FORCE] ? ctrl[F_THRESH+:2]
                                       : {1'b0, ctrl[F_ROLE]};
            rp_sel <= (rp_f == 2'h3) ? 2'h0 : rp_f;
        end
    end

    // ------------------------------------------------------------
    // VCONN fault
    // ------------------------------------------------------------
    // Pin to switch is three cycles, far inside the open budget
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_s1 <= 1'b0;
            fault_s2 <= 1'b0;
            vconn_sw <= 1'b0;
        end else begin
            fault_s1 <= vconn_fault;
            fault_s2 <= fault_s1;
            vconn_sw <= ctrl[F_VCONN] & ~fault_s2;
        end
    end

    // ------------------------------------------------------------
    // Power-up announce and sampling timers
    // ------------------------------------------------------------
    logic [22:0] init_cnt;
    logic init_done;
    logic [22:0] samp_cnt;
    wire [22:0] cc_base = 23'(CC_CYCLES);
    wire [1:0] samp_sel = ctrl[F_SAMP+:2];
    wire [22:0] samp_period = (samp_sel == 2'h0) ? (cc_base >> 1) :
                              (samp_sel == 2'h1) ? cc_base :
                              (samp_sel == 2'h2) ? (cc_base << 1) : (cc_base << 2);
    wire init_hit = ~init_done & (init_cnt == 23'(INIT_CYCLES - 2));
    wire samp_hit = (samp_cnt >= samp_period - 23'h000001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt <= 23'h000000;
            init_done <= 1'b0;
            samp_cnt <= 23'h000000;
            cc_sample_stb <= 1'b0;
            vbus_sample_stb <= 1'b0;
        end else begin
            init_cnt <= init_done ? init_cnt : init_cnt + 23'h000001;
            init_done <= init_done | init_hit;
            samp_cnt <= samp_hit ? 23'h000000 : samp_cnt + 23'h000001;
            cc_sample_stb <= samp_hit;
            vbus_sample_stb <= samp_hit;
        end
    end

    // ------------------------------------------------------------
    // Alerts and interrupt
    // ------------------------------------------------------------
    logic rx_good;
    logic rx_bad;
    logic tx_end_manual;
    assign set_ev = {samp_hit, rx_bad, tx_end_manual, rx_good, fault_s2, init_hit};

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert <= '0;
            int_n <= 1'b1;
        end else begin
            alert <= (alert & ~clr_mask) | set_ev;
            int_n <= ~|(alert & alert_en);
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    logic rclk_s1, rclk_s2, rclk_s3;
    logic rdat_s1, rdat_s2, rdat_s3;
    logic rfrm_s1, rfrm_s2, rfrm_s3;
    logic [1:0] trans_cnt;
    logic [11:0] idle_cnt;
    logic [31:0] rx_crc;
    logic [31:0] rx_shift;
    logic [9:0] rx_bits;
    logic gcrc_pend;
    wire rx_fall = rclk_s3 & ~rclk_s2;
    wire frm_start = rfrm_s2 & ~rfrm_s3;
    wire frm_end = rfrm_s3 & ~rfrm_s2;
    wire dat_edge = rdat_s2 ^ rdat_s3;
    wire [31:0] rx_next = {rdat_s2, rx_shift[31:1]};
    wire frame_ok = (rx_crc == CRC_RESIDUE) & (rx_bits >= 10'(MIN_RX_BITS))
                    & (rx_bits[4:0] == 5'h00) & line_busy;
    assign line_busy = (trans_cnt == 2'(N_TRANS));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {rclk_s1, rclk_s2, rclk_s3} <= 3'h0;
            {rdat_s1, rdat_s2, rdat_s3} <= 3'h0;
            {rfrm_s1, rfrm_s2, rfrm_s3} <= 3'h0;
        end else begin
            {rclk_s1, rclk_s2, rclk_s3} <= {rx_clk, rclk_s1, rclk_s2};
            {rdat_s1, rdat_s2, rdat_s3} <= {rx_data, rdat_s1, rdat_s2};
            {rfrm_s1, rfrm_s2, rfrm_s3} <= {rx_frame, rfrm_s1, rfrm_s2};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trans_cnt <= 2'h0;
            idle_cnt <= 12'h000;
        end else if (dat_edge) begin
            idle_cnt <= 12'h000;
            trans_cnt <= line_busy ? trans_cnt : trans_cnt + 2'h1;
        end else if (idle_cnt == 12'(RX_IDLE_CYC)) begin
            trans_cnt <= 2'h0;
        end else begin
            idle_cnt <= idle_cnt + 12'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_crc <= CRC_INIT;
            rx_shift <= 32'h00000000;
            rx_bits <= 10'h000;
            rx_head <= 32'h00000000;
            rx_good <= 1'b0;
            rx_bad <= 1'b0;
        end else begin
            rx_good <= phy_en & frm_end & frame_ok;
            rx_bad <= phy_en & frm_end & ~frame_ok;
            if (frm_start) begin
                rx_crc <= CRC_INIT;
                rx_bits <= 10'h000;
            end else if (rfrm_s2 & rx_fall & phy_en) begin
                rx_crc <= crc_step(rx_crc, rdat_s2);
                rx_shift <= rx_next;
                rx_bits <= rx_bits + 10'h001;
                if (rx_bits == 10'h01F) begin
                    rx_head <= rx_next;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    logic [8:0] half_cnt;
    logic [4:0] bit_idx;
    logic [3:0] word_idx;
    logic [31:0] tx_crc;
    logic tx_auto;
    wire half_tick = (half_cnt == 9'(HALF_BIT_CYC - 1));
    wire [31:0] body_word = tx_auto ? GOODCRC_WORD : tx_mem[word_idx[2:0]];
    wire cur_bit = (tx_state == TX_CRC) ? ~tx_crc[bit_idx] : body_word[bit_idx];
    wire last_word = tx_auto | (word_idx == tx_len);
    wire go_manual = wr_tx_cmd & pwdata[F_TXGO] & phy_en;
    wire start_tx = (tx_state == TX_IDLE) & phy_en & (gcrc_pend | go_manual);
    wire crc_last = (tx_state == TX_CRC) & half_tick & tx_clk & (bit_idx == 5'h1F);

    always_ff @(posedge pclk) begin
        if (wr_tx_data) begin
            tx_mem[wr_ptr[2:0]] <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= 4'h0;
            tx_len <= 4'h0;
            gcrc_pend <= 1'b0;
        end else begin
            wr_ptr <= wr_tx_cmd ? 4'h0 : wr_ptr + {3'h0, wr_tx_data};
            if (wr_tx_cmd) begin
                tx_len <= pwdata[F_TXLEN+:4] & 4'(TX_WORDS - 1);
            end
            // Reply waits for a frame this port is already sending; line_busy is not checked
            gcrc_pend <= phy_en & (rx_good | (gcrc_pend & ~start_tx));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TX_IDLE;
            half_cnt <= 9'h000;
            bit_idx <= 5'h00;
            word_idx <= 4'h0;
            tx_crc <= CRC_INIT;
            tx_auto <= 1'b0;
            tx_clk <= 1'b0;
            tx_data <= 1'b0;
            tx_oe <= 1'b0;
            tx_end_manual <= 1'b0;
        end else begin
            tx_end_manual <= crc_last & ~tx_auto;
            half_cnt <= (half_tick | (tx_state == TX_IDLE)) ? 9'h000 : half_cnt + 9'h001;
            case (tx_state)
                TX_IDLE: begin
                    tx_clk <= 1'b0;
                    tx_data <= 1'b0;
                    // Drive drops a cycle after the last fall, so the far end keeps hold
                    tx_oe <= start_tx;
                    if (start_tx) begin
                        tx_state <= TX_BODY;
                        tx_auto <= gcrc_pend;
                        bit_idx <= 5'h00;
                        word_idx <= 4'h0;
                        tx_crc <= CRC_INIT;
                    end
                end
                TX_BODY, TX_CRC: begin
                    if (half_tick & ~tx_clk) begin
                        tx_clk <= 1'b1;
                        tx_data <= cur_bit;
                    end else if (half_tick) begin
                        tx_clk <= 1'b0;
                        bit_idx <= bit_idx + 5'h01;
                        if (tx_state == TX_BODY) begin
                            tx_crc <= crc_step(tx_crc, cur_bit);
                            if (bit_idx == 5'h1F) begin
                                word_idx <= word_idx + 4'h1;
                                tx_state <= last_word ? TX_CRC : TX_BODY;
                            end
                        end else if (bit_idx == 5'h1F) begin
                            tx_state <= TX_IDLE;
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    vconn_open_a: assert property ($rose(fault_s2) |=> !vconn_sw)
        else $error("vconn switch not opened after fault");
    vconn_flag_a: assert property ($rose(fault_s2) |=> alert[B_VCONN])
        else $error("vconn fault flag not set");
    init_irq_a: assert property (init_hit && alert_en[B_INIT] |=> ##1 !int_n)
        else $error("init interrupt missing");
    samp_bound_a: assert property ($stable(samp_sel) |-> samp_cnt < samp_period)
        else $error("sampling period exceeded");
    phy_on_a: assert property (attached && ctrl[F_RXDET+:2] != 2'h0 |=> phy_en)
        else $error("phy not enabled");
    phy_off_a: assert property (!attached |=> !phy_en)
        else $error("phy enabled while unattached");
    thresh_role_a: assert property (!ctrl[F_FORCE] |=>
        rx_thresh == {1'b0, $past(ctrl[F_ROLE])})
        else $error("threshold not from power role");
    thresh_force_a: assert property (ctrl[F_FORCE] |=>
        rx_thresh == $past(ctrl[F_THRESH+:2]))
        else $error("forced threshold ignored");
    rp_level_a: assert property (rp_f != 2'h3 |=> rp_sel == $past(rp_f))
        else $error("rp level mismatch");
    line_busy_a: assert property ($rose(line_busy) |-> $past(dat_edge))
        else $error("busy without transition");
    irq_level_a: assert property (|(alert & alert_en) |=> !int_n)
        else $error("interrupt not held");
    irq_rel_a: assert property (!(|(alert & alert_en)) |=> int_n)
        else $error("interrupt not released");
    goodcrc_a: assert property (rx_good && phy_en |=>
        gcrc_pend || tx_state != TX_IDLE)
        else $error("goodcrc reply not queued");
    crc_phase_a: assert property (crc_last |=> tx_state == TX_IDLE
        ##1 tx_oe == (tx_state == TX_BODY))
        else $error("frame not closed after crc");

    tx_done_c: cover property (tx_end_manual);
    rx_good_c: cover property (rx_good ##[1:1000] tx_oe);
    rx_bad_c: cover property (rx_bad);
    fault_c: cover property ($rose(fault_s2));

endmodule

// File: pd_link_partner.sv
`timescale 1ns/1ps
module pd_link_partner import port_controller_if_pkg::*; (
    output logic rx_clk,
    output logic rx_data,
    output logic rx_frame,
    input wire logic tx_clk,
    input wire logic tx_data,
    input wire logic tx_oe
);
    // ----------------------------------------
    // Far end of the CC wire
    // ----------------------------------------
    logic [63:0] cap;
    int ncap = 0;
    initial begin
        rx_clk = 1'b0;
        rx_data = 1'b0;
        rx_frame = 1'b0;
        cap = 64'h0;
    end
    // Bits move with tx_clk rising, so take them on the fall
    always @(negedge tx_clk) begin
        if (tx_oe === 1'b1) begin
            cap = {tx_data, cap[63:1]};
            ncap++;
        end
    end
    function automatic logic [31:0] crc32(input logic [31:0] w);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 32; i++) c = (c[0] ^ w[i]) ? (c >> 1) ^ CRC_POLY : c >> 1;
        return c;
    endfunction
    // Clock only runs inside a frame; bad flips one check bit
    task automatic send(input logic [31:0] w, input logic bad);
        logic [63:0] f;
        f = {~crc32(w) ^ {31'h0, bad}, w};
        rx_frame = 1'b1;
        for (int i = 0; i < 64; i++) begin
            rx_data = f[i];
            #8 rx_clk = 1'b1;
            #32 rx_clk = 1'b0;
            #24;
        end
        rx_frame = 1'b0;
        // Released line shows the inverse, never a stale bit
        rx_data = ~rx_data;
    endtask
endmodule

// File: typec_pd_port_controller_core_tb_top.sv
`timescale 1ns/1ps
module typec_pd_port_controller_core_tb_top import port_controller_if_pkg::*;;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    localparam int INIT_P = 50;
    localparam int CC_P = 64;
    logic pclk, presetn, psel, penable, pwrite, vconn_fault, pready, pslverr, int_n;
    logic vconn_sw, phy_en, cc_sample_stb, vbus_sample_stb, tx_clk, tx_data, tx_oe;
    logic rx_clk, rx_data, rx_frame;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, w, seed;
    logic [1:0] rx_thresh, rp_sel, thr;
    logic [64:0] notes[$];
    logic [64:0] nt;
    int error_cnt = 0;
    int total_checks = 0;
    int n;
    port_controller_if_core #(.INIT_CYCLES(INIT_P), .CC_CYCLES(CC_P), .TX_WORDS(8)) port_controller_if_core_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .int_n(int_n), .vconn_fault(vconn_fault), .vconn_sw(vconn_sw),
        .phy_en(phy_en), .rx_thresh(rx_thresh), .rp_sel(rp_sel),
        .cc_sample_stb(cc_sample_stb), .vbus_sample_stb(vbus_sample_stb),
        .tx_clk(tx_clk), .tx_data(tx_data), .tx_oe(tx_oe), .rx_clk(rx_clk),
        .rx_data(rx_data), .rx_frame(rx_frame));
    pd_link_partner pd_link_partner_i (.rx_clk(rx_clk), .rx_data(rx_data),
        .rx_frame(rx_frame), .tx_clk(tx_clk), .tx_data(tx_data), .tx_oe(tx_oe));
    task automatic test_done();
        if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask
    // Reads leave their expectation in the queue for the monitor
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] e = 0, input logic [31:0] m = 0, input logic err = 0);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) notes.push_back({err, m, e});
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            nt = notes.pop_front();
            check("prdata", prdata & nt[63:32], nt[31:0] & nt[63:32]);
            check("pslverr", {31'h0, pslverr}, {31'h0, nt[64]});
        end
    end
    function automatic logic [31:0] ctrl(input logic [2:0] att, input logic [1:0] rp,
            input logic [1:0] th, input logic f, input logic r, input logic [1:0] det,
            input logic vc);
        return {18'h0, vc, att, rp, 2'b01, th, f, r, det};
    endfunction
    task automatic wait_frame(input logic [31:0] exp);
        n = 0;
        while (tx_oe !== 1'b1 && n < 3000) begin tick(1); n++; end
        while (tx_oe !== 1'b0 && n < 60000) begin tick(1); n++; end
        check("tx_bits", pd_link_partner_i.ncap, 64);
        check("tx_word", pd_link_partner_i.cap[31:0], exp);
        check("tx_crc", pd_link_partner_i.cap[63:32], ~pd_link_partner_i.crc32(exp));
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Full run is near 90k cycles, mostly two 64-bit link frames
    initial begin
        repeat (98000) @(posedge pclk);
        error_cnt++;
        test_done();
    end
    initial begin
        seed = 32'hB2D1;
        {presetn, psel, penable, pwrite, vconn_fault, paddr, pwdata} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        n = 0;
        while (int_n !== 1'b0 && n < INIT_P + 20) begin tick(1); n++; end
        check("int_n", {31'h0, int_n}, 32'h0);
        check("init_time", n <= INIT_P, 1);
        apb(0, ADDR_ALERT, 0, 32'h1, 32'h1);
        apb(0, ADDR_CTRL, 0, 32'h40, 32'h3FFF);
        apb(0, ADDR_ALERT_EN, 0, 32'h1F, 32'h3F);
        apb(0, 8'h20, 0, 0, 0, 1'b1);
        apb(1, ADDR_ALERT_CLR, 32'h3F);
        tick(3);
        check("int_n", {31'h0, int_n}, 32'h1);
        n = 0;
        while (cc_sample_stb !== 1'b1 && n < 200) begin tick(1); n++; end
        n = 0;
        do begin tick(1); n++; end while (cc_sample_stb !== 1'b1 && n < 200);
        check("cc_period", n, CC_P);
        check("vbus_stb", {31'h0, vbus_sample_stb}, 32'h1);
        apb(1, ADDR_CTRL, ctrl(3'd0, 2'd0, 2'd0, 1'b0, 1'b0, 2'd3, 1'b0));
        tick(3);
        check("phy_off", {31'h0, phy_en}, 32'h0);
        for (int a = 1; a <= 4; a++) begin
            thr = 2'($random(seed));
            apb(1, ADDR_CTRL, ctrl(3'(a), 2'(a - 1), thr, a > 2, a[0], 2'(a % 3 + 1), 1'b0));
            tick(3);
            check("phy_on", {31'h0, phy_en}, 32'h1);
            check("thresh", rx_thresh, (a > 2) ? thr : {1'b0, a[0]});
            check("rp_sel", rp_sel, (a == 4) ? 0 : a - 1);
        end
        apb(1, ADDR_CTRL, ctrl(3'd1, 2'd0, 2'd0, 1'b0, 1'b0, 2'd1, 1'b1));
        tick(3);
        check("vconn_sw", {31'h0, vconn_sw}, 32'h1);
        @(posedge pclk);
        vconn_fault <= 1'b1;
        n = 0;
        do begin tick(1); n++; end while (vconn_sw !== 1'b0 && n < 20);
        check("vconn_open", n <= VCONN_OPEN_CYC, 1);
        apb(0, ADDR_ALERT, 0, 32'h2, 32'h2);
        check("int_n", {31'h0, int_n}, 32'h0);
        vconn_fault <= 1'b0;
        apb(1, ADDR_ALERT_CLR, 32'h3F);
        tick(3);
        check("int_n", {31'h0, int_n}, 32'h1);
        w = $random(seed);
        apb(1, ADDR_TX_CMD, 32'h0);
        apb(1, ADDR_TX_DATA, w);
        pd_link_partner_i.ncap = 0;
        apb(1, ADDR_TX_CMD, 32'h100);
        wait_frame(w);
        apb(0, ADDR_ALERT, 0, 32'h8, 32'h8);
        apb(1, ADDR_ALERT_CLR, 32'h3F);
        w = {w[31:4], 4'h5};
        pd_link_partner_i.send(w, 1'b1);
        tick(40);
        apb(0, ADDR_ALERT, 0, 32'h10, 32'h1C);
        check("no_reply", {31'h0, tx_oe}, 32'h0);
        apb(1, ADDR_ALERT_CLR, 32'h3F);
        tick(1400);
        pd_link_partner_i.ncap = 0;
        pd_link_partner_i.send(w, 1'b0);
        wait_frame(GOODCRC_WORD);
        apb(0, ADDR_ALERT, 0, 32'h4, 32'h4);
        apb(0, ADDR_RX_HEAD, 0, w, 32'hFFFFFFFF);
        check("int_n", {31'h0, int_n}, 32'h0);
        test_done();
    end
endmodule
